// ===== design/sbsr_pkg.sv
// constants and carriers of the status reporting block
// assumes a command parser and output queue on the same clock
package sbsr_pkg;
   // =====================================================
   // summary byte bit positions
   localparam int SB_QUES = 3;
   localparam int SB_MSG  = 4;
   localparam int SB_EVT  = 5;
   localparam int SB_RQS  = 6;
   localparam logic [7:0] SB_USED   = 8'h78;
   localparam logic [7:0] SB_SRCMSK = 8'h38;
   // =====================================================
   // common event latch bit positions
   localparam int EV_OPC = 0;
   localparam int EV_QRY = 2;
   localparam int EV_DEV = 3;
   localparam int EV_EXE = 4;
   localparam int EV_CMD = 5;
   localparam int EV_PON = 7;
   localparam logic [7:0] EV_USED = 8'hBD;
   // =====================================================
   // questionable event bit positions
   localparam int QU_VOLT = 0;
   localparam int QU_CURR = 1;
   localparam int QU_OHM  = 9;
   localparam int QU_LO   = 11;
   localparam int QU_HI   = 12;
   localparam logic [15:0] QU_USED = 16'h1A03;
   // =====================================================
   // reset values
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   // =====================================================
   // carriers
   typedef struct packed {
      logic        clear_status;
      logic        event_query;
      logic        ques_query;
      logic        summary_query;
      logic        serial_poll;
      logic        sre_write;
      logic        ese_write;
      logic        ques_en_write;
      logic        ques_preset;
      logic [15:0] value;
   } sbsr_cmd_t;
   typedef struct packed {
      logic opc_done;
      logic query_err;
      logic device_err;
      logic exec_err;
      logic cmd_err;
      logic ovld_volt;
      logic ovld_curr;
      logic ovld_ohm;
      logic limit_lo;
      logic limit_hi;
   } sbsr_evt_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } sbsr_resp_t;
endpackage : sbsr_pkg

// ===== design/sbsr_top.sv
// status summary byte, common event latch, questionable latch and service request
// assumes commands and events arrive as one-cycle pulses on SYS_CLK from the parser,
// and that the parser delivers commands in received order

// Contract
// - message pending sets summary bit 4 immediately
// - summary bits follow sources, never latched
// - clearing event register clears its summary
// - message bit clears when queue empty
// - bit 3 is OR of enabled questionable
// - bit 5 is OR of enabled events
// - enable mask picks summaries driving bit 6
// - bit 6 rising asserts service request
// - poll or cause read clears request
// - poll returns byte, clears only bit 6
// - summary query keeps bit 6 intact
// - summary query waits for prior commands
// - operation complete sets event bit 0
// - query errors set event bit 2
// - device errors set event bit 3
// - execution bit 4, syntax bit 5
// - power cycle sets event bit 7
// - overload reports bit 3 and questionable
// - event bits latch until cleared
module sbsr_top (
   // clock and reset
   input  wire logic               SYS_CLK,
   input  wire logic               RST,
   // commands and events from the parser
   input  wire sbsr_pkg::sbsr_cmd_t CMD,
   input  wire sbsr_pkg::sbsr_evt_t EVT,
   input  wire logic               EXEC_IDLE,
   input  wire logic               OUTPUT_MESSAGE_PENDING,
   // stored power-on settings
   input  wire logic               PSC_STORED,
   input  wire logic [7:0]         SRE_STORED,
   input  wire logic [7:0]         ESE_STORED,
   // bus side
   output logic                    SRQ_REQ,
   output logic                    POLL_VALID,
   output logic [7:0]              POLL_DATA,
   output sbsr_pkg::sbsr_resp_t    RESP,
   // register views
   output logic [7:0]              SERVICE_SUMMARY_BYTE,
   output logic [7:0]              COMMON_EVENT_LATCH,
   output logic [15:0]             QUES_EVENT,
   output logic [7:0]              SRE_MASK,
   output logic [7:0]              ESE_MASK,
   output logic [15:0]             QUES_MASK
);
   // =====================================================
   // state
   logic        pwr_init_r;
   logic [7:0]  cev_r, cev_nxt;
   logic [15:0] qev_r, qev_nxt;
   logic [7:0]  sre_r, sre_nxt;
   logic [7:0]  ese_r, ese_nxt;
   logic [15:0] qen_r, qen_nxt;
   logic        rqs_r, rqs_nxt;
   logic        mss_prev_r;
   logic [7:0]  cause_r, cause_nxt;
   logic        sq_pend_r, sq_pend_nxt;
   logic [7:0]  sum_byte_r;
   logic        poll_valid_r;
   logic [7:0]  poll_data_r;
   sbsr_pkg::sbsr_resp_t resp_r, resp_nxt;

   // =====================================================
   // event latches
   logic [7:0]  cev_set;
   logic [15:0] qev_set;
   logic        cev_clr;
   logic        qev_clr;

   assign cev_set[sbsr_pkg::EV_OPC] = EVT.opc_done;
   assign cev_set[sbsr_pkg::EV_QRY] = EVT.query_err;
   assign cev_set[sbsr_pkg::EV_DEV] = EVT.device_err | EVT.ovld_volt | EVT.ovld_curr | EVT.ovld_ohm;
   assign cev_set[sbsr_pkg::EV_EXE] = EVT.exec_err;
   assign cev_set[sbsr_pkg::EV_CMD] = EVT.cmd_err;
   assign cev_set[sbsr_pkg::EV_PON] = pwr_init_r;
   assign cev_set[1] = 1'b0;
   assign cev_set[6] = 1'b0;

   // overload also lands in questionable latch
   always_comb begin
      qev_set                   = sbsr_pkg::WORD_ZERO;
      qev_set[sbsr_pkg::QU_VOLT] = EVT.ovld_volt;
      qev_set[sbsr_pkg::QU_CURR] = EVT.ovld_curr;
      qev_set[sbsr_pkg::QU_OHM]  = EVT.ovld_ohm;
      qev_set[sbsr_pkg::QU_LO]   = EVT.limit_lo;
      qev_set[sbsr_pkg::QU_HI]   = EVT.limit_hi;
   end

   // clear-status or the latch's own query (event or questionable) empties it
   assign cev_clr = CMD.clear_status | CMD.event_query;
   assign qev_clr = CMD.clear_status | CMD.ques_query;
   // set-only latch; a set in the clear cycle survives
   assign cev_nxt = ((cev_clr ? sbsr_pkg::BYTE_ZERO : cev_r) | cev_set) & sbsr_pkg::EV_USED;
   assign qev_nxt = ((qev_clr ? sbsr_pkg::WORD_ZERO : qev_r) | qev_set) & sbsr_pkg::QU_USED;

   // =====================================================
   // enable masks
   // zero write or power-on with clear setting empties mask
   assign sre_nxt = pwr_init_r    ? (PSC_STORED ? sbsr_pkg::BYTE_ZERO : SRE_STORED) :
                    CMD.sre_write ? CMD.value[7:0] : sre_r;
   assign ese_nxt = pwr_init_r    ? (PSC_STORED ? sbsr_pkg::BYTE_ZERO : ESE_STORED) :
                    CMD.ese_write ? CMD.value[7:0] : ese_r;
   // questionable mask is not retained over power-on, preset empties it
   assign qen_nxt = CMD.ques_preset   ? sbsr_pkg::WORD_ZERO :
                    CMD.ques_en_write ? CMD.value : qen_r;

   // =====================================================
   // summary byte
   logic [7:0] sum_src;
   logic [7:0] sum_full;
   logic [7:0] mss_src;
   logic       mss;

   // summaries are plain functions of their sources
   always_comb begin
      sum_src = sbsr_pkg::BYTE_ZERO;
      sum_src[sbsr_pkg::SB_QUES] = |(qev_r & qen_r);
      sum_src[sbsr_pkg::SB_MSG]  = OUTPUT_MESSAGE_PENDING;
      // enabled event bits, drop with the latch
      sum_src[sbsr_pkg::SB_EVT]  = |(cev_r & ese_r);
   end

   assign sum_full = (sum_src | (rqs_r ? (8'h01 << sbsr_pkg::SB_RQS) : sbsr_pkg::BYTE_ZERO)) & sbsr_pkg::SB_USED;

   // mask selects which summaries request service
   assign mss_src = sum_src & sre_r & sbsr_pkg::SB_SRCMSK;
   assign mss     = |mss_src;

   // =====================================================
   // service request
   logic rqs_set;
   logic rqs_clr;

   assign rqs_set = mss & ~mss_prev_r;
   // poll, or reading the latch that caused it
   assign rqs_clr = CMD.serial_poll |
                    (cev_clr & cause_r[sbsr_pkg::SB_EVT]) |
                    (qev_clr & cause_r[sbsr_pkg::SB_QUES]);
   // only the request bit is cleared; set wins over clear
   assign rqs_nxt   = rqs_set | (rqs_r & ~rqs_clr);
   assign cause_nxt = rqs_set ? mss_src : (rqs_nxt ? cause_r : sbsr_pkg::BYTE_ZERO);

   // =====================================================
   // query answers
   logic sq_go;

   // summary query waits until earlier commands are done
   assign sq_go       = sq_pend_r & EXEC_IDLE & ~CMD.event_query & ~CMD.ques_query;
   assign sq_pend_nxt = CMD.summary_query | (sq_pend_r & ~sq_go);

   // summary query reports bit 6 without clearing it
   always_comb begin
      resp_nxt.valid = CMD.event_query | CMD.ques_query | sq_go;
      resp_nxt.data  = sbsr_pkg::WORD_ZERO;
      if (CMD.event_query) begin
         resp_nxt.data = {8'h00, cev_r};
      end else if (CMD.ques_query) begin
         resp_nxt.data = qev_r;
      end else if (sq_go) begin
         resp_nxt.data = {8'h00, sum_full};
      end
   end

   // =====================================================
   // registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pwr_init_r <= 1'b1;
         cev_r      <= sbsr_pkg::BYTE_ZERO;
         qev_r      <= sbsr_pkg::WORD_ZERO;
         sre_r      <= sbsr_pkg::BYTE_ZERO;
         ese_r      <= sbsr_pkg::BYTE_ZERO;
         qen_r      <= sbsr_pkg::WORD_ZERO;
      end else begin
         pwr_init_r <= 1'b0;
         cev_r      <= cev_nxt;
         qev_r      <= qev_nxt;
         sre_r      <= sre_nxt;
         ese_r      <= ese_nxt;
         qen_r      <= qen_nxt;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rqs_r      <= 1'b0;
         mss_prev_r <= 1'b0;
         cause_r    <= sbsr_pkg::BYTE_ZERO;
         sq_pend_r  <= 1'b0;
      end else begin
         rqs_r      <= rqs_nxt;
         mss_prev_r <= mss;
         cause_r    <= cause_nxt;
         sq_pend_r  <= sq_pend_nxt;
      end
   end

   // serial poll is answered by the bus side at once, no command ordering
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sum_byte_r   <= sbsr_pkg::BYTE_ZERO;
         poll_valid_r <= 1'b0;
         poll_data_r  <= sbsr_pkg::BYTE_ZERO;
         resp_r       <= '0;
      end else begin
         sum_byte_r   <= sum_full;
         poll_valid_r <= CMD.serial_poll;
         poll_data_r  <= CMD.serial_poll ? sum_full : poll_data_r;
         resp_r       <= resp_nxt;
      end
   end

   // =====================================================
   // outputs
   assign SRQ_REQ              = rqs_r;
   assign POLL_VALID           = poll_valid_r;
   assign POLL_DATA            = poll_data_r;
   assign RESP                 = resp_r;
   assign SERVICE_SUMMARY_BYTE = sum_byte_r;
   assign COMMON_EVENT_LATCH   = cev_r;
   assign QUES_EVENT           = qev_r;
   assign SRE_MASK             = sre_r;
   assign ESE_MASK             = ese_r;
   assign QUES_MASK            = qen_r;

   // =====================================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_msg_sets: assert property (OUTPUT_MESSAGE_PENDING |=> SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_MSG])
      else $error("message bit not set");
   a_msg_clears: assert property (!OUTPUT_MESSAGE_PENDING |=> !SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_MSG])
      else $error("message bit stuck");
   a_evt_summary: assert property (##1 SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_EVT] == $past(|(cev_r & ese_r)))
      else $error("event summary wrong");
   a_ques_summary: assert property (##1 SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_QUES] == $past(|(qev_r & qen_r)))
      else $error("questionable summary wrong");
   a_srq_rise: assert property (mss && !mss_prev_r |=> SRQ_REQ)
      else $error("request not raised");
   a_poll_clears: assert property (CMD.serial_poll && !rqs_set |=> !SRQ_REQ)
      else $error("poll left request set");
   a_poll_data: assert property (CMD.serial_poll |=> POLL_VALID && POLL_DATA == $past(sum_full))
      else $error("poll data wrong");
   a_query_keeps: assert property (sq_go && rqs_r && !rqs_clr |=> SRQ_REQ)
      else $error("summary query cleared request");
   a_query_waits: assert property (!EXEC_IDLE && !CMD.event_query && !CMD.ques_query |=> !RESP.valid)
      else $error("summary query answered early");
   a_evt_latched: assert property (!cev_clr |=> (COMMON_EVENT_LATCH & $past(cev_r)) == $past(cev_r))
      else $error("event bit lost");
   a_evt_clear: assert property (cev_clr && cev_set == 8'h00 |=> COMMON_EVENT_LATCH == 8'h00)
      else $error("event latch not cleared");
   a_overload: assert property (EVT.ovld_ohm |=> COMMON_EVENT_LATCH[sbsr_pkg::EV_DEV] && QUES_EVENT[sbsr_pkg::QU_OHM])
      else $error("overload not reported");
   a_unused_zero: assert property (((SERVICE_SUMMARY_BYTE & ~sbsr_pkg::SB_USED) == 8'h00) &&
                                   ((COMMON_EVENT_LATCH & ~sbsr_pkg::EV_USED) == 8'h00))
      else $error("unused bit set");

   // a new event in the clear cycle wins over the clear, so such cycles are left out
   a_clear_summary: assert property (CMD.clear_status && EVT == '0 |=> ##1
                                     !SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_EVT] && !SERVICE_SUMMARY_BYTE[sbsr_pkg::SB_QUES])
      else $error("summary kept after clear");
   a_cause_read: assert property (CMD.event_query && cause_r[sbsr_pkg::SB_EVT] && !rqs_set |=> !SRQ_REQ)
      else $error("cause read left request set");
   a_sre_zero: assert property (CMD.sre_write && !pwr_init_r && CMD.value[7:0] == 8'h00 |=>
                                SRE_MASK == 8'h00)
      else $error("enable mask not cleared");
   a_power_on: assert property (pwr_init_r |=> COMMON_EVENT_LATCH[sbsr_pkg::EV_PON])
      else $error("power-on bit not set");
   a_opc_sets: assert property (EVT.opc_done |=> COMMON_EVENT_LATCH[sbsr_pkg::EV_OPC])
      else $error("completion bit not set");
   a_exec_sets: assert property (EVT.exec_err |=> COMMON_EVENT_LATCH[sbsr_pkg::EV_EXE])
      else $error("execution bit not set");
   a_syntax_sets: assert property (EVT.cmd_err |=> COMMON_EVENT_LATCH[sbsr_pkg::EV_CMD])
      else $error("syntax bit not set");

   // =====================================================
   // coverage of main scenarios
   c_request: cover property (rqs_set ##[1:20] CMD.serial_poll);
   c_query_wait: cover property (CMD.summary_query ##1 !EXEC_IDLE [*4] ##1 sq_go);
   c_set_on_clear: cover property (cev_clr && EVT.cmd_err);
   c_power_clear: cover property (pwr_init_r && PSC_STORED);
   c_cause_read: cover property (cev_clr && cause_r[sbsr_pkg::SB_EVT] && rqs_r);
endmodule : sbsr_top

// ===== dv/sbsr_ctl_model.sv
// controller side model: turns bench requests into one-cycle command pulses
// assumes the bench raises go for one cycle per request
module sbsr_ctl_model (
   // clock and reset
   input  wire logic           sys_clk,
   input  wire logic           rst,
   // requests from the bench
   input  wire logic           go,
   input  wire logic [3:0]     sel,
   input  wire logic [15:0]    val,
   // commands toward the device
   output sbsr_pkg::sbsr_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd <= '0;
      end else if (go) begin
         cmd <= {9'(9'h100 >> sel), val};
      end else begin
         // idle data scrambled so nothing leans on a stale value
         cmd <= {9'h000, ~cmd.value};
      end
   end
endmodule : sbsr_ctl_model

// ===== dv/sbsr_top_tb.sv
// self-checking bench for the status reporting block
// assumes one 50 MHz clock and the controller model on the command side
module sbsr_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals
   logic                 sys_clk, rst, idle, msg, psc, go;
   logic [3:0]           sel;
   logic [15:0]          val;
   sbsr_pkg::sbsr_cmd_t  cmd;
   sbsr_pkg::sbsr_evt_t  evt;
   sbsr_pkg::sbsr_resp_t resp;
   logic                 srq, pv;
   logic [7:0]           pd, ssb, cel, srem, esem;
   logic [15:0]          que, qum;
   int                   n_errors = 0, total_checks = 0, cyc = 0;
   logic [9:0]  ev_t  [10] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020,
                               10'h010, 10'h008, 10'h004, 10'h002, 10'h001};
   logic [7:0]  lat_t [10] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20,
                               8'h08, 8'h08, 8'h08, 8'h00, 8'h00};
   logic [15:0] qu_t  [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                               16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};
   // ==========================================
   // instances
   sbsr_top i_dut (.SYS_CLK(sys_clk), .RST(rst), .CMD(cmd), .EVT(evt), .EXEC_IDLE(idle),
      .OUTPUT_MESSAGE_PENDING(msg), .PSC_STORED(psc), .SRE_STORED(8'h30), .ESE_STORED(8'h3D),
      .SRQ_REQ(srq), .POLL_VALID(pv), .POLL_DATA(pd), .RESP(resp), .SERVICE_SUMMARY_BYTE(ssb),
      .COMMON_EVENT_LATCH(cel), .QUES_EVENT(que), .SRE_MASK(srem), .ESE_MASK(esem),
      .QUES_MASK(qum));
   sbsr_ctl_model i_ctl (.sys_clk(sys_clk), .rst(rst), .go(go), .sel(sel), .val(val), .cmd(cmd));
   // ==========================================
   // clock and watchdog
   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   // run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         close_out();
      end
   end
   // ==========================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic issue(input logic [3:0] s, input logic [15:0] v);
      @(posedge sys_clk);
      go <= 1'h1;
      sel <= s;
      val <= v;
      @(posedge sys_clk);
      go <= 1'h0;
   endtask : issue
   task automatic pulse(input logic [9:0] e);
      @(posedge sys_clk);
      evt <= e;
      @(posedge sys_clk);
      evt <= '0;
      tick(3);
   endtask : pulse
   // a missing answer counts as one mismatch
   task automatic wait_resp();
      for (int i = 0; i < 10; i++) begin
         tick(1);
         if (resp.valid === 1'h1 || pv === 1'h1) return;
      end
      chk(16'h0000, 16'h0001);
   endtask : wait_resp
   task automatic close_out();
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   // ==========================================
   // main sequence
   initial begin
      rst = 1'h1;
      idle = 1'h1;
      msg = 1'h0;
      psc = 1'h0;
      go = 1'h0;
      sel = 4'h0;
      val = 16'h0000;
      evt = '0;
      for (int p = 0; p < 2; p++) begin
         rst <= 1'h1;
         psc <= p[0];
         repeat (4) @(posedge sys_clk);
         rst <= 1'h0;
         tick(2);
         chk(16'(cel), 16'h0080);
         chk(16'(srem), p ? 16'h0000 : 16'h0030);
         chk(16'(esem), p ? 16'h0000 : 16'h003D);
      end
      issue(4'h0, 16'h0000);
      issue(4'h6, 16'h00FF);
      issue(4'h7, 16'hFFFF);
      issue(4'h5, 16'h0028);
      tick(2);
      chk(16'(cel), 16'h0000);
      chk(qum, 16'hFFFF);
      // table: one event source per row, then clear status
      for (int i = 0; i < 10; i++) begin
         pulse(ev_t[i]);
         chk(16'(cel), 16'(lat_t[i]));
         chk(que, qu_t[i]);
         chk(16'(ssb), {10'h001, |lat_t[i], 1'h0, |qu_t[i], 3'h0});
         chk(16'(srq), 16'h0001);
         issue(4'h0, 16'h0000);
         tick(3);
         chk(16'(ssb), 16'h0000);
         chk(16'(srq), 16'h0000);
      end
      // message pending, delayed summary query, then poll
      issue(4'h5, 16'h0010);
      @(posedge sys_clk);
      msg <= 1'h1;
      idle <= 1'h0;
      tick(3);
      chk(16'(ssb), 16'h0050);
      issue(4'h3, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         tick(1);
         chk(16'(resp.valid), 16'h0000);
      end
      @(posedge sys_clk);
      idle <= 1'h1;
      wait_resp();
      chk(resp.data, 16'h0050);
      chk(16'(srq), 16'h0001);
      issue(4'h4, 16'h0000);
      wait_resp();
      chk(16'(pd), 16'h0050);
      chk(16'(srq), 16'h0000);
      tick(1);
      chk(16'(ssb), 16'h0010);
      @(posedge sys_clk);
      msg <= 1'h0;
      tick(2);
      chk(16'(ssb), 16'h0000);
      // completion detection sequence
      issue(4'h0, 16'h0000);
      issue(4'h6, 16'h0001);
      issue(4'h5, 16'h0000);
      tick(2);
      chk(16'(srem), 16'h0000);
      pulse(10'h200);
      chk(16'(ssb), 16'h0020);
      chk(16'(srq), 16'h0000);
      issue(4'h5, 16'h0020);
      tick(3);
      chk(16'(srq), 16'h0001);
      issue(4'h1, 16'h0000);
      wait_resp();
      chk(resp.data, 16'h0001);
      tick(2);
      chk(16'(cel), 16'h0000);
      chk(16'(srq), 16'h0000);
      // questionable query clears only its own summary bit
      pulse(10'h201);
      issue(4'h2, 16'h0000);
      wait_resp();
      chk(resp.data, 16'h1000);
      tick(2);
      chk(16'(ssb & 8'h38), 16'h0020);
      issue(4'h8, 16'h0000);
      tick(2);
      chk(qum, 16'h0000);
      // clear and a new event in one cycle: the event survives
      @(posedge sys_clk);
      go <= 1'h1;
      sel <= 4'h0;
      val <= 16'h0000;
      @(posedge sys_clk);
      go <= 1'h0;
      evt <= 10'h020;
      @(posedge sys_clk);
      evt <= '0;
      tick(2);
      chk(16'(cel), 16'h0020);
      close_out();
   end
endmodule : sbsr_top_tb
